// >>> hbf_params.svh
// constants for the half-bridge fault manager host controller
`ifndef HBF_PARAMS_SVH
`define HBF_PARAMS_SVH
// Functional notes
// RL1: Low supply undervoltage pulls fault line, outputs off.
// RL2: Low supply undervoltage fault is not latched.
// RL3: Floating undervoltage disables high side only, silently.
// RL4: High side needs fresh rising input after recovery.
// RL5: Desat pulses shorter than filter time ignored.
// RL6: Desat blanked after each output turn-on.
// RL7: Desat after blanking starts turning output off.
// RL8: Soft shutdown uses only soft pull-down.
// RL9: Sync line low for whole soft shutdown.
// RL10: After soft shutdown, fault latched until cleared.
// RL11: Soft shutdown masks undervoltage and external shutdown.
// RL12: Desat only evaluated while output is on.
// RL13: Sync line shared; only desaturating driver pulls it.
// RL14: Sync line low freezes both outputs.
// RL15: Desat detection still works and wins while frozen.
// RL16: Fault line shared open-drain; low forces outputs off.
// RL17: External fault low not latched, clear cannot override.
// RL18: Clear held during soft shutdown suppresses fault latch.
// RL19: Controller holds fault clear during power-up.
// RL20: Controller aborts start-up when sync line goes low.
// RL21: Both inputs high drives both outputs low.
// RL22: After clear or release, outputs follow inputs.
// RL23: Inputs synchronised, intervals are cycle counters; the controller reads sync and fault lines unsynchronised.

// clock
`define HBF_CLK_PERIOD_NS 8
// start-up pulse: minimum low-input and clear pulse, rounded up
`define HBF_PULSE_US 15
`define HBF_PULSE_CYC ((`HBF_PULSE_US * 1000 + `HBF_CLK_PERIOD_NS - 1) / `HBF_CLK_PERIOD_NS)
// supply settle time with clear held before charging the bootstrap
`define HBF_SETTLE_US 15
`define HBF_SETTLE_CYC ((`HBF_SETTLE_US * 1000 + `HBF_CLK_PERIOD_NS - 1) / `HBF_CLK_PERIOD_NS)

// register byte offsets
`define HBF_OFF_CTRL 8'h00
`define HBF_OFF_GATE 8'h04
`define HBF_OFF_STAT 8'h08

// control register fields
`define HBF_CTRL_START 0
`define HBF_CTRL_RUN 1
`define HBF_CTRL_FORCE_SD 2
`define HBF_CTRL_FCLR 3
`define HBF_CTRL_ABCLR 4
// gate register fields
`define HBF_GATE_HS 0
`define HBF_GATE_LS 1
// status register fields
`define HBF_STAT_STATE_LSB 0
`define HBF_STAT_SYNC_LOW 4
`define HBF_STAT_FAULT_LOW 5
`define HBF_STAT_ABORTED 6
`define HBF_STAT_CLR_BUSY 7

// reset values
`define HBF_CTRL_RST 2'h0
`define HBF_GATE_RST 2'h0
`endif

// >>> hbf_pkg.sv
// types shared by the host controller and its register slave
package hbf_pkg;
	typedef enum logic [2:0] {
		HBF_IDLE = 3'b000,
		HBF_SETTLE = 3'b001,
		HBF_CHARGE = 3'b010,
		HBF_RELEASE = 3'b011,
		HBF_RUN = 3'b100,
		HBF_ABORT = 3'b101
	} hbf_state_e;

	// levels held in registers
	typedef struct packed {
		logic run_en;
		logic force_sd;
		logic gate_hs;
		logic gate_ls;
	} hbf_ctrl_s;

	// one-cycle command pulses
	typedef struct packed {
		logic start;
		logic fault_clr;
		logic abort_clr;
	} hbf_cmd_s;

	// state reported to software
	typedef struct packed {
		hbf_state_e state;
		logic sync_low;
		logic fault_low;
		logic aborted;
		logic clr_busy;
	} hbf_stat_s;
endpackage

// >>> hbf_apb_regs.sv
// apb slave holding the controller's own control, gate and status registers
`timescale 1ns/1ps
`include "hbf_params.svh"
module hbf_apb_regs
	import hbf_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output hbf_ctrl_s ctrl,
	output hbf_cmd_s cmd,
	input wire hbf_stat_s stat
);
	if (ADDR_W < 4) begin : g_bad_addr
		$error("hbf_apb_regs: ADDR_W too small for the register map");
	end

	logic [1:0] ctrl_q;
	logic [1:0] gate_q;
	logic [31:0] rdata_q;
	hbf_cmd_s cmd_q;
	logic wr_en;

	// mapped-word check, used only for the error answer; the read path compares offsets itself
	function automatic logic hbf_hit(input logic [ADDR_W-1:0] a);
		hbf_hit = (a == ADDR_W'(`HBF_OFF_CTRL)) || (a == ADDR_W'(`HBF_OFF_GATE)) ||
			(a == ADDR_W'(`HBF_OFF_STAT));
	endfunction

	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hbf_hit(paddr);
	assign wr_en = psel & penable & pwrite;
	assign prdata = rdata_q;

	// control levels: run enable and forced shutdown
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `HBF_CTRL_RST;
		end else if (wr_en && paddr == ADDR_W'(`HBF_OFF_CTRL)) begin
			ctrl_q <= {pwdata[`HBF_CTRL_RUN], pwdata[`HBF_CTRL_FORCE_SD]};
		end
	end

	// gate command levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_q <= `HBF_GATE_RST;
		end else if (wr_en && paddr == ADDR_W'(`HBF_OFF_GATE)) begin
			gate_q <= {pwdata[`HBF_GATE_HS], pwdata[`HBF_GATE_LS]};
		end
	end

	// command bits self-clear, so software never has to write a zero back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_q <= '0;
		end else if (wr_en && paddr == ADDR_W'(`HBF_OFF_CTRL)) begin
			cmd_q <= '{start: pwdata[`HBF_CTRL_START], fault_clr: pwdata[`HBF_CTRL_FCLR],
				abort_clr: pwdata[`HBF_CTRL_ABCLR]};
		end else begin
			cmd_q <= '0;
		end
	end

	// read data captured in the setup cycle, valid through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			rdata_q <= 32'h0;
			if (paddr == ADDR_W'(`HBF_OFF_CTRL)) begin
				rdata_q[`HBF_CTRL_RUN] <= ctrl_q[1];
				rdata_q[`HBF_CTRL_FORCE_SD] <= ctrl_q[0];
			end else if (paddr == ADDR_W'(`HBF_OFF_GATE)) begin
				rdata_q[`HBF_GATE_HS] <= gate_q[1];
				rdata_q[`HBF_GATE_LS] <= gate_q[0];
			end else if (paddr == ADDR_W'(`HBF_OFF_STAT)) begin
				rdata_q[`HBF_STAT_STATE_LSB+2:`HBF_STAT_STATE_LSB] <= stat.state;
				rdata_q[`HBF_STAT_SYNC_LOW] <= stat.sync_low;
				rdata_q[`HBF_STAT_FAULT_LOW] <= stat.fault_low;
				rdata_q[`HBF_STAT_ABORTED] <= stat.aborted;
				rdata_q[`HBF_STAT_CLR_BUSY] <= stat.clr_busy;
			end
		end
	end

	assign ctrl = '{run_en: ctrl_q[1], force_sd: ctrl_q[0], gate_hs: gate_q[1],
		gate_ls: gate_q[0]};
	assign cmd = cmd_q;
endmodule

// >>> hbf_ctrl.sv
// host controller: start-up sequence, gate commands and shared-line handling
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "hbf_params.svh"
module hbf_ctrl
	import hbf_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int CNT_W = 12,
	parameter int PULSE_CYC = `HBF_PULSE_CYC,
	parameter int SETTLE_CYC = `HBF_SETTLE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic high_cmd,
	output logic low_cmd,
	output logic fault_clear_input,
	input wire logic sync_freeze_line_i,
	output logic sync_freeze_line_o,
	output logic sync_freeze_line_oe,
	input wire logic fault_shutdown_line_i,
	output logic fault_shutdown_line_o,
	output logic fault_shutdown_line_oe
);
	if (PULSE_CYC < 1 || SETTLE_CYC < 1 || PULSE_CYC >= (1 << CNT_W) ||
		SETTLE_CYC >= (1 << CNT_W)) begin : g_bad_cnt
		$error("hbf_ctrl: interval counts do not fit the counter");
	end

	hbf_ctrl_s ctrl;
	hbf_cmd_s cmd;
	hbf_stat_s stat;
	hbf_state_e state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] clr_cnt_q;
	logic clr_pend_q;
	logic clr_busy_q;
	logic aborted_q;
	logic high_q, low_q, fclr_q, fsd_oe_q;
	logic in_startup;

	hbf_apb_regs #(
		.ADDR_W(ADDR_W)
	) u_regs (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.ctrl(ctrl),
		.cmd(cmd),
		.stat(stat)
	);

	////////////////////////////////////////////////////////////////////////////////
	// start-up sequencer

	assign in_startup = (state_q == HBF_SETTLE) || (state_q == HBF_CHARGE) ||
		(state_q == HBF_RELEASE);

	// next state: clear held first, then bootstrap charge, then release low input
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			HBF_IDLE: begin
				if (cmd.start) begin
					state_d = HBF_SETTLE;
					cnt_d = CNT_W'(SETTLE_CYC - 1);
				end
			end
			HBF_SETTLE, HBF_CHARGE, HBF_RELEASE: begin
				if (!sync_freeze_line_i) begin
					state_d = HBF_ABORT; // RL20
				end else if (cnt_q != '0) begin
					cnt_d = cnt_q - 1'b1;
				end else if (state_q == HBF_SETTLE) begin
					state_d = HBF_CHARGE;
					cnt_d = CNT_W'(PULSE_CYC - 1);
				end else if (state_q == HBF_CHARGE) begin
					state_d = HBF_RELEASE;
					cnt_d = CNT_W'(PULSE_CYC - 1);
				end else begin
					state_d = HBF_RUN;
				end
			end
			HBF_ABORT: begin
				if (cmd.abort_clr) begin
					state_d = HBF_IDLE;
				end
			end
			HBF_RUN: begin
				state_d = HBF_RUN;
			end
			default: begin
				state_d = HBF_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= HBF_IDLE;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// aborted flag: set on a sync low during start-up, cleared only from abort
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aborted_q <= 1'b0;
		end else if (in_startup && !sync_freeze_line_i) begin
			aborted_q <= 1'b1; // RL20
		end else if (cmd.abort_clr && state_q == HBF_ABORT) begin
			aborted_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fault clear pulse in normal running

	// a clear waits while sync is low so it cannot cut into a soft shutdown
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clr_pend_q <= 1'b0;
			clr_busy_q <= 1'b0;
			clr_cnt_q <= '0;
		end else if (state_q != HBF_RUN) begin
			clr_pend_q <= 1'b0;
			clr_busy_q <= 1'b0;
			clr_cnt_q <= '0;
		end else if (clr_busy_q) begin
			clr_pend_q <= clr_pend_q | cmd.fault_clr;
			if (clr_cnt_q == '0) begin
				clr_busy_q <= 1'b0;
			end else begin
				clr_cnt_q <= clr_cnt_q - 1'b1;
			end
		end else if ((clr_pend_q || cmd.fault_clr) && sync_freeze_line_i) begin
			clr_pend_q <= 1'b0;
			clr_busy_q <= 1'b1;
			clr_cnt_q <= CNT_W'(PULSE_CYC - 1);
		end else begin
			clr_pend_q <= clr_pend_q | cmd.fault_clr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// device pins

	// pin levels follow the next state so they change on the same edge as it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_q <= 1'b0;
			low_q <= 1'b0;
			fclr_q <= 1'b0;
		end else begin
			high_q <= 1'b0;
			low_q <= 1'b0;
			fclr_q <= 1'b0;
			case (state_d)
				HBF_SETTLE, HBF_RELEASE: begin
					fclr_q <= 1'b1; // RL19
				end
				HBF_CHARGE: begin
					fclr_q <= 1'b1; // RL19
					low_q <= 1'b1; // low side on charges the bootstrap
				end
				HBF_RUN: begin
					// never both on: the driver would blank both anyway
					high_q <= ctrl.run_en & ctrl.gate_hs & ~ctrl.gate_ls;
					low_q <= ctrl.run_en & ctrl.gate_ls & ~ctrl.gate_hs;
					fclr_q <= clr_busy_q;
				end
				default: begin
					fclr_q <= 1'b0;
				end
			endcase
		end
	end

	// forced shutdown only pulls the shared fault line, never drives it high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fsd_oe_q <= 1'b0;
		end else begin
			fsd_oe_q <= ctrl.force_sd; // RL16
		end
	end

	assign high_cmd = high_q;
	assign low_cmd = low_q;
	assign fault_clear_input = fclr_q;
	assign fault_shutdown_line_o = 1'b0;
	assign fault_shutdown_line_oe = fsd_oe_q;
	// the controller only listens on the sync line
	assign sync_freeze_line_o = 1'b0; // RL13
	assign sync_freeze_line_oe = 1'b0; // RL13

	assign stat = '{state: state_q, sync_low: ~sync_freeze_line_i,
		fault_low: ~fault_shutdown_line_i, aborted: aborted_q, clr_busy: clr_busy_q};

	////////////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_sync_lost;
		(in_startup && !sync_freeze_line_i);
	endsequence

	sequence s_aborted_quiet;
		(state_q == HBF_ABORT && !high_cmd && !low_cmd && aborted_q);
	endsequence

	property p_sync_listen_only;
		@(posedge pclk) disable iff (!presetn)
		!sync_freeze_line_oe;
	endproperty
	a_sync_listen_only: assert property (p_sync_listen_only) else $error("sync line driven"); // RL13

	property p_force_sd_pulls;
		@(posedge pclk) disable iff (!presetn)
		ctrl.force_sd |=> (fault_shutdown_line_oe && !fault_shutdown_line_o);
	endproperty
	a_force_sd_pulls: assert property (p_force_sd_pulls) else $error("forced shutdown not driven"); // RL16

	property p_no_force_no_pull;
		@(posedge pclk) disable iff (!presetn)
		$fell(ctrl.force_sd) |=> !fault_shutdown_line_oe;
	endproperty
	a_no_force_no_pull: assert property (p_no_force_no_pull) else $error("fault line not released"); // RL16

	property p_clear_held_startup;
		@(posedge pclk) disable iff (!presetn)
		in_startup |-> fault_clear_input;
	endproperty
	a_clear_held_startup: assert property (p_clear_held_startup) else $error("clear dropped in start-up"); // RL19

	property p_abort_on_sync;
		@(posedge pclk) disable iff (!presetn)
		s_sync_lost |=> s_aborted_quiet;
	endproperty
	a_abort_on_sync: assert property (p_abort_on_sync) else $error("start-up not aborted"); // RL20

	property p_abort_stays;
		@(posedge pclk) disable iff (!presetn)
		(state_q == HBF_ABORT && !cmd.abort_clr) |=> (state_q == HBF_ABORT && !low_cmd);
	endproperty
	a_abort_stays: assert property (p_abort_stays) else $error("abort left without clear"); // RL20
endmodule

// >>> hbf_drv_model.sv
// behavioural gate driver seen across the controller's pins
`timescale 1ns/1ps
module hbf_drv_model #(
	parameter int BLANK = 3,
	parameter int FILT = 2,
	parameter int SOFT_T = 8
) (
	input wire logic pclk,
	input wire logic rst_n,
	input wire logic high_cmd,
	input wire logic low_cmd,
	input wire logic fault_clear_input,
	input wire logic sync_line,
	input wire logic fault_line,
	input wire logic [1:0] desat,
	input wire logic low_supply_fail,
	input wire logic float_supply_fail,
	output logic [1:0] out_q,
	output logic [1:0] soft_off,
	output logic sync_oe,
	output logic fault_oe
);
	logic [7:0] on_q [2];
	logic [7:0] filt_q [2];
	logic [7:0] soft_q;
	logic side_q, latch_q, nolatch_q, arm_q, hin_q;
	logic [1:0] hit;

	////////////////////////////////////////
	// a sense counts only once its side is on and blanking has run out
	assign hit[0] = filt_q[0] == 8'(FILT);
	assign hit[1] = filt_q[1] == 8'(FILT);
	assign sync_oe = soft_q != 8'h00;
	// a supply sag during a soft shutdown only shows once that shutdown is over
	assign fault_oe = latch_q | (low_supply_fail & ~sync_oe);
	assign soft_off = sync_oe ? (side_q ? 2'b10 : 2'b01) : 2'b00;

	// blanking and filter counters, restarted at every turn-on
	always_ff @(posedge pclk or negedge rst_n) begin
		for (int s = 0; s < 2; s++) begin
			if (!rst_n || !out_q[s] || sync_oe) begin
				on_q[s] <= 8'h00;
				filt_q[s] <= 8'h00;
			end else begin
				on_q[s] <= (on_q[s] < 8'(BLANK)) ? on_q[s] + 8'h01 : on_q[s];
				filt_q[s] <= (desat[s] && on_q[s] == 8'(BLANK)) ? filt_q[s] + 8'h01 : 8'h00;
			end
		end
	end

	// soft shutdown, fault latch and output steering; clear sampled at start
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			soft_q <= 8'h00;
			side_q <= 1'b0;
			latch_q <= 1'b0;
			nolatch_q <= 1'b0;
			arm_q <= 1'b0;
			hin_q <= 1'b0;
			out_q <= 2'b00;
		end else begin
			hin_q <= high_cmd;
			if (float_supply_fail)
				arm_q <= 1'b0;
			else if (high_cmd && !hin_q)
				arm_q <= 1'b1;
			if (fault_clear_input)
				latch_q <= 1'b0;
			if (|hit) begin
				soft_q <= 8'(SOFT_T);
				side_q <= hit[1];
				nolatch_q <= fault_clear_input;
				out_q <= out_q & ~hit;
			end else if (sync_oe) begin
				soft_q <= soft_q - 8'h01;
				if (soft_q == 8'h01 && !nolatch_q) begin
					latch_q <= 1'b1;
					out_q <= 2'b00;
				end
			end else if (!fault_line || low_supply_fail)
				out_q <= 2'b00;
			else if (sync_line)
				out_q <= {high_cmd & ~low_cmd & arm_q & ~float_supply_fail,
					low_cmd & ~high_cmd};
		end
	end
endmodule

// >>> hbf_ctrl_tb.sv
// self-checking bench for the host controller against a behavioural driver
`timescale 1ns/1ps
`include "hbf_params.svh"
module hbf_ctrl_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, high_cmd, low_cmd, fault_clear_input;
	logic sync_o, sync_oe, flt_o, flt_oe, m_sync_oe, m_flt_oe;
	logic [1:0] desat = 2'b00;
	logic low_supply_fail = 1'b0;
	logic float_supply_fail = 1'b0;
	logic [1:0] out_q, soft_off;
	int fail_count = 0;
	int n_tests = 0;
	// open-drain lines: low when any party pulls, else the pull-up wins
	wire sync_line = (sync_oe ? sync_o : 1'b1) && !m_sync_oe;
	wire fault_line = (flt_oe ? flt_o : 1'b1) && !m_flt_oe;

	initial forever #4 pclk = ~pclk;

	hbf_ctrl #(.PULSE_CYC(12), .SETTLE_CYC(4)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .high_cmd(high_cmd),
		.low_cmd(low_cmd), .fault_clear_input(fault_clear_input),
		.sync_freeze_line_i(sync_line), .sync_freeze_line_o(sync_o),
		.sync_freeze_line_oe(sync_oe), .fault_shutdown_line_i(fault_line),
		.fault_shutdown_line_o(flt_o), .fault_shutdown_line_oe(flt_oe));
	hbf_drv_model #(.SOFT_T(20)) drv (.pclk(pclk), .rst_n(presetn), .high_cmd(high_cmd),
		.low_cmd(low_cmd), .fault_clear_input(fault_clear_input), .sync_line(sync_line),
		.fault_line(fault_line), .desat(desat), .low_supply_fail(low_supply_fail),
		.float_supply_fail(float_supply_fail),
		.out_q(out_q), .soft_off(soft_off), .sync_oe(m_sync_oe), .fault_oe(m_flt_oe));

	////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one apb transfer; the request stands until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// sample just after the edges so registered outputs have settled
	task automatic look(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic t_regs();
		apb(1'b0, `HBF_OFF_CTRL, 32'h0);
		chk("ctrl rst", rd, 32'h0);
		apb(1'b0, `HBF_OFF_STAT, 32'h0);
		chk("stat rst", rd, 32'h0);
		apb(1'b1, 8'h0c, 32'hff);
		chk("wr slverr", 32'(er), 32'h1);
		apb(1'b0, 8'h0c, 32'h0);
		chk("rd unmapped", {rd[30:0], er}, 32'h1);
	endtask

	// desaturation while charging: the start-up must stop
	task automatic t_abort();
		@(posedge pclk);
		desat <= 2'b01;
		apb(1'b1, `HBF_OFF_CTRL, 32'h1);
		look(40);
		chk("abort pins", {low_cmd, fault_clear_input}, 32'h0);
		chk("no latch", 32'(fault_line), 32'h1);
		apb(1'b0, `HBF_OFF_STAT, 32'h0);
		chk("abort stat", rd, 32'h45);
		@(posedge pclk);
		desat <= 2'b00;
		apb(1'b1, `HBF_OFF_CTRL, 32'h10);
		apb(1'b0, `HBF_OFF_STAT, 32'h0);
		chk("idle stat", rd, 32'h0);
	endtask

	task automatic t_start();
		apb(1'b1, `HBF_OFF_CTRL, 32'h3);
		look(3);
		chk("settle", {fault_clear_input, low_cmd}, 32'h2);
		look(6);
		chk("charge", {fault_clear_input, low_cmd}, 32'h3);
		look(12);
		chk("release", {fault_clear_input, low_cmd}, 32'h2);
		look(12);
		chk("run", {fault_clear_input, low_cmd}, 32'h0);
		apb(1'b0, `HBF_OFF_STAT, 32'h0);
		chk("run stat", rd, 32'h4);
	endtask

	// every gate pair, reserved bits set on write
	task automatic t_gate();
		logic [1:0] g;
		apb(1'b0, `HBF_OFF_CTRL, 32'h0);
		chk("ctrl rd", rd, 32'h2);
		for (int i = 0; i < 4; i++) begin
			g = 2'(i);
			apb(1'b1, `HBF_OFF_GATE, {30'h3fffffff, g});
			look(4);
			chk("cmds", {high_cmd, low_cmd}, {g[0] & ~g[1], g[1] & ~g[0]});
			chk("outs", 32'(out_q), {g[0] & ~g[1], g[1] & ~g[0]});
			apb(1'b0, `HBF_OFF_GATE, 32'h0);
			chk("gate rd", rd, 32'(g));
		end
	endtask

	task automatic t_desat();
		apb(1'b1, `HBF_OFF_GATE, 32'h1);
		look(12);
		@(posedge pclk);
		desat <= 2'b10;
		@(posedge pclk);
		desat <= 2'b00;
		look(4);
		chk("short pulse", {sync_line, out_q}, 32'h6);
		@(posedge pclk);
		desat <= 2'b10;
		look(4);
		chk("soft off", {sync_line, soft_off}, 32'h2);
		apb(1'b1, `HBF_OFF_CTRL, 32'ha);
		look(2);
		chk("clear held", 32'(fault_clear_input), 32'h0);
		apb(1'b0, `HBF_OFF_STAT, 32'h0);
		chk("sync stat", rd & 32'h3f, 32'h14);
		@(posedge pclk);
		desat <= 2'b00;
		look(50);
		chk("recovered", {fault_line, out_q}, 32'h6);
	endtask

	task automatic t_force();
		apb(1'b1, `HBF_OFF_CTRL, 32'h6);
		look(3);
		chk("forced", {fault_line, out_q}, 32'h0);
		apb(1'b1, `HBF_OFF_CTRL, 32'he);
		look(2);
		chk("clear pulse", 32'(fault_clear_input), 32'h1);
		apb(1'b0, `HBF_OFF_STAT, 32'h0);
		chk("fault stat", rd & 32'hbf, 32'ha4);
		look(18);
		chk("no override", 32'(out_q), 32'h0);
		apb(1'b1, `HBF_OFF_CTRL, 32'h2);
		look(4);
		chk("released", 32'(out_q), 32'h2);
	endtask

	// supply sags on the driver side: what the controller sees and what still works
	task automatic t_supply();
		@(posedge pclk);
		low_supply_fail <= 1'b1;
		look(3);
		chk("low sag", {fault_line, out_q}, 32'h0);
		apb(1'b0, `HBF_OFF_STAT, 32'h0);
		chk("low sag stat", rd & 32'h3f, 32'h24);
		@(posedge pclk);
		low_supply_fail <= 1'b0;
		look(3);
		chk("low sag gone", {fault_line, out_q}, 32'h6);
		@(posedge pclk);
		float_supply_fail <= 1'b1;
		look(3);
		chk("float sag", {fault_line, out_q}, 32'h4);
		apb(1'b1, `HBF_OFF_GATE, 32'h2);
		look(4);
		chk("low alive", 32'(out_q), 32'h1);
		// the high request rises while the floating side is still down
		apb(1'b1, `HBF_OFF_GATE, 32'h1);
		look(3);
		@(posedge pclk);
		float_supply_fail <= 1'b0;
		look(4);
		chk("no fresh edge", 32'(out_q), 32'h0);
		apb(1'b1, `HBF_OFF_GATE, 32'h0);
		apb(1'b1, `HBF_OFF_GATE, 32'h1);
		look(4);
		chk("fresh edge", 32'(out_q), 32'h2);
		apb(1'b1, `HBF_OFF_CTRL, 32'h0);
		look(3);
		chk("run off", {high_cmd, low_cmd}, 32'h0);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	////////////////////////////////////////
	// main sequence; each scenario judges its own results
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_abort();
		t_start();
		t_gate();
		t_desat();
		t_force();
		t_supply();
		complete_run();
	end

	// the run needs a few hundred cycles at most, so this only trips on a hang
	initial begin
		#50us;
		fail_count++;
		complete_run();
	end
endmodule
